// *** rtl/rpit_mgr.sv ***
// return path id table manager with command port and register slave
//
// Local design decisions: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none
module rpit_mgr #(
  parameter int ENTRIES = rpit_pkg::ENTRIES_DEF,
  parameter int UID_W = rpit_pkg::UID_W_DEF,
  parameter int RP_W = rpit_pkg::RP_W_DEF,
  parameter int PORT_W = rpit_pkg::PORT_W_DEF,
  localparam int IW = (ENTRIES > 1) ? $clog2(ENTRIES) : 1
) (
  input wire logic I_CLK,
  input wire logic I_RSTN,
  input wire logic I_CMD_VALID,
  output logic O_CMD_READY,
  input wire logic [2:0] I_CMD_OP,
  input wire logic I_CMD_DR,
  input wire logic I_CMD_RCTE,
  input wire logic [UID_W-1:0] I_CMD_UID,
  input wire logic [RP_W-1:0] I_CMD_RP,
  input wire logic [PORT_W-1:0] I_CMD_PORT,
  input wire logic [IW-1:0] I_CMD_RPID,
  output logic O_RSP_VALID,
  input wire logic I_RSP_READY,
  output logic [IW-1:0] O_RSP_RPID,
  output logic O_RSP_HIT,
  output logic O_RSP_ITF,
  output logic [RP_W-1:0] O_RSP_RP,
  output logic [PORT_W-1:0] O_RSP_PORT,
  output logic O_CFG_PERMIT,
  input wire logic I_AXI_AWVALID,
  output logic O_AXI_AWREADY,
  input wire logic [7:0] I_AXI_AWADDR,
  input wire logic I_AXI_WVALID,
  output logic O_AXI_WREADY,
  input wire logic [31:0] I_AXI_WDATA,
  input wire logic [3:0] I_AXI_WSTRB,
  output logic O_AXI_BVALID,
  input wire logic I_AXI_BREADY,
  output logic [1:0] O_AXI_BRESP,
  input wire logic I_AXI_ARVALID,
  output logic O_AXI_ARREADY,
  input wire logic [7:0] I_AXI_ARADDR,
  output logic O_AXI_RVALID,
  input wire logic I_AXI_RREADY,
  output logic [31:0] O_AXI_RDATA,
  output logic [1:0] O_AXI_RRESP
);
  if (ENTRIES < 2 || ENTRIES > 4096 || UID_W > 64 || RP_W > 32 || PORT_W > 8) begin : g_chk
    $error("rpit_mgr: unsupported parameter values");
  end

  typedef struct packed {
    rpit_pkg::rpit_fsm_t fsm;
    logic [ENTRIES-1:0][1:0] stat;
    logic [ENTRIES-1:0][UID_W-1:0] uid;
    logic [ENTRIES-1:0][RP_W-1:0] rp;
    logic [ENTRIES-1:0][PORT_W-1:0] port;
    logic [IW-1:0] rsp_rpid;
    logic rsp_hit;
    logic rsp_itf;
    logic [RP_W-1:0] rsp_rp;
    logic [PORT_W-1:0] rsp_port;
    logic [UID_W-1:0] last_uid;
    logic resp_only;
    logic [IW-1:0] index;
    logic aw_ok;
    logic [7:0] awaddr;
    logic w_ok;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } rpit_state_t;

  rpit_state_t s;
  rpit_state_t next_s;

  // table search results, lowest index wins in every class
  logic full_hit;
  logic [IW-1:0] hit_idx;
  logic held_hit;
  logic [IW-1:0] held_idx;
  logic free_hit;
  logic [IW-1:0] free_idx;
  logic q_hit;
  logic [IW-1:0] q_idx;
  logic last_live;
  logic any_valid;
  logic cmd_take;

  assign cmd_take = I_CMD_VALID && O_CMD_READY;

  always_comb begin
    full_hit = 1'b0;
    hit_idx = '0;
    held_hit = 1'b0;
    held_idx = '0;
    free_hit = 1'b0;
    free_idx = '0;
    q_hit = 1'b0;
    q_idx = '0;
    last_live = 1'b0;
    any_valid = 1'b0;
    for (int i = ENTRIES - 1; i >= 0; i--) begin
      if (s.stat[i][1] && s.uid[i] == I_CMD_UID && s.rp[i] == I_CMD_RP && s.port[i] == I_CMD_PORT) begin
        full_hit = 1'b1;
        hit_idx = IW'(i);
      end
      if (s.stat[i] == rpit_pkg::STAT_HELD && s.uid[i] == I_CMD_UID) begin
        held_hit = 1'b1;
        held_idx = IW'(i);
      end
      if (s.stat[i] == rpit_pkg::STAT_FREE) begin
        free_hit = 1'b1;
        free_idx = IW'(i);
      end
      if (s.stat[i] != rpit_pkg::STAT_FREE && s.uid[i] == I_CMD_UID) begin
        q_hit = 1'b1;
        q_idx = IW'(i);
      end
      if (s.stat[i] != rpit_pkg::STAT_FREE && s.uid[i] == s.last_uid) begin
        last_live = 1'b1;
      end
      if (s.stat[i] == rpit_pkg::STAT_VALID) begin
        any_valid = 1'b1;
      end
    end
  end

  logic [IW-1:0] alloc_idx;
  logic can_alloc;

  assign can_alloc = held_hit || free_hit;
  assign alloc_idx = held_hit ? held_idx : free_idx;

  always_comb begin
    next_s = s;
    if (s.fsm == rpit_pkg::ST_IDLE && I_CMD_VALID) begin
      next_s.fsm = rpit_pkg::ST_REPLY;
      next_s.last_uid = I_CMD_UID;
      next_s.rsp_hit = 1'b0;
      next_s.rsp_itf = 1'b0;
      next_s.rsp_rpid = '0;
      next_s.rsp_rp = '0;
      next_s.rsp_port = '0;
      case (I_CMD_OP)
        rpit_pkg::OP_QUERY_NODE: begin
          if (!I_CMD_DR) begin
            if (full_hit) begin
              next_s.rsp_hit = 1'b1;
              next_s.rsp_rpid = hit_idx;
            end else if (can_alloc) begin
              next_s.stat[alloc_idx] = rpit_pkg::STAT_VALID;
              next_s.port[alloc_idx] = I_CMD_PORT;
              next_s.rp[alloc_idx] = I_CMD_RP;
              next_s.uid[alloc_idx] = I_CMD_UID;
              next_s.rsp_hit = 1'b1;
              next_s.rsp_rpid = alloc_idx;
            end else begin
              next_s.rsp_itf = 1'b1;
            end
          end
        end
        rpit_pkg::OP_QUIESCE: begin
          for (int i = 0; i < ENTRIES; i++) begin
            if (s.stat[i] != rpit_pkg::STAT_FREE && s.uid[i] == I_CMD_UID) begin
              if (!I_CMD_RCTE && IW'(i) == q_idx) begin
                next_s.stat[i] = rpit_pkg::STAT_HELD;
              end else begin
                next_s.stat[i] = rpit_pkg::STAT_FREE;
              end
            end
          end
        end
        rpit_pkg::OP_QUERY_REG: begin
          for (int i = 0; i < ENTRIES; i++) begin
            if (s.stat[i] == rpit_pkg::STAT_VALID) begin
              next_s.stat[i] = rpit_pkg::STAT_REPORTED;
            end
          end
        end
        rpit_pkg::OP_RESET_FRAME: begin
          for (int i = 0; i < ENTRIES; i++) begin
            next_s.stat[i] = rpit_pkg::STAT_FREE;
          end
        end
        rpit_pkg::OP_LOOKUP: begin
          if (s.stat[I_CMD_RPID][1]) begin
            next_s.rsp_hit = 1'b1;
            next_s.rsp_rpid = I_CMD_RPID;
            next_s.rsp_rp = s.rp[I_CMD_RPID];
            next_s.rsp_port = s.port[I_CMD_RPID];
          end
        end
        default: begin
        end
      endcase
    end else if (s.fsm == rpit_pkg::ST_REPLY && I_RSP_READY) begin
      next_s.fsm = rpit_pkg::ST_IDLE;
    end

    // register slave: address and data are caught in either order
    if (I_AXI_AWVALID && O_AXI_AWREADY) begin
      next_s.aw_ok = 1'b1;
      next_s.awaddr = I_AXI_AWADDR;
    end
    if (I_AXI_WVALID && O_AXI_WREADY) begin
      next_s.w_ok = 1'b1;
      next_s.wdata = I_AXI_WDATA;
      next_s.wstrb = I_AXI_WSTRB;
    end
    if (s.bvalid && I_AXI_BREADY) begin
      next_s.bvalid = 1'b0;
    end
    if (s.aw_ok && s.w_ok && !s.bvalid) begin
      next_s.aw_ok = 1'b0;
      next_s.w_ok = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = rpit_pkg::RESP_OKAY;
      if (s.awaddr == rpit_pkg::REG_CTRL) begin
        if (s.wstrb[0]) begin
          next_s.resp_only = s.wdata[rpit_pkg::CTRL_RESP_ONLY_BIT];
        end
      end else if (s.awaddr == rpit_pkg::REG_INDEX) begin
        if (s.wstrb[0]) begin
          next_s.index = s.wdata[IW-1:0];
        end
      end else if (s.awaddr == rpit_pkg::REG_STATUS || s.awaddr == rpit_pkg::REG_ENT_STAT ||
                   s.awaddr == rpit_pkg::REG_ENT_RP || s.awaddr == rpit_pkg::REG_ENT_UID_LO ||
                   s.awaddr == rpit_pkg::REG_ENT_UID_HI) begin
        next_s.bresp = rpit_pkg::RESP_OKAY;
      end else begin
        next_s.bresp = rpit_pkg::RESP_DECERR;
      end
    end
    if (s.rvalid && I_AXI_RREADY) begin
      next_s.rvalid = 1'b0;
    end
    if (I_AXI_ARVALID && O_AXI_ARREADY) begin
      next_s.rvalid = 1'b1;
      next_s.rresp = rpit_pkg::RESP_OKAY;
      next_s.rdata = '0;
      if (I_AXI_ARADDR == rpit_pkg::REG_CTRL) begin
        next_s.rdata[rpit_pkg::CTRL_RESP_ONLY_BIT] = s.resp_only;
      end else if (I_AXI_ARADDR == rpit_pkg::REG_STATUS) begin
        next_s.rdata[0] = (s.fsm == rpit_pkg::ST_REPLY);
        next_s.rdata[1] = !free_hit;
        next_s.rdata[2] = any_valid;
      end else if (I_AXI_ARADDR == rpit_pkg::REG_INDEX) begin
        next_s.rdata[IW-1:0] = s.index;
      end else if (I_AXI_ARADDR == rpit_pkg::REG_ENT_STAT) begin
        next_s.rdata[1:0] = s.stat[s.index];
        next_s.rdata[rpit_pkg::ENT_PORT_LSB +: PORT_W] = s.port[s.index];
      end else if (I_AXI_ARADDR == rpit_pkg::REG_ENT_RP) begin
        next_s.rdata[RP_W-1:0] = s.rp[s.index];
      end else if (I_AXI_ARADDR == rpit_pkg::REG_ENT_UID_LO) begin
        next_s.rdata = 32'(64'(s.uid[s.index]));
      end else if (I_AXI_ARADDR == rpit_pkg::REG_ENT_UID_HI) begin
        next_s.rdata = 32'(64'(s.uid[s.index]) >> 32);
      end else begin
        next_s.rresp = rpit_pkg::RESP_DECERR;
      end
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RSTN) begin
      s <= '0;
      s.resp_only <= rpit_pkg::CTRL_RST[rpit_pkg::CTRL_RESP_ONLY_BIT];
    end else begin
      s <= next_s;
    end
  end

  assign O_CMD_READY = (s.fsm == rpit_pkg::ST_IDLE);
  assign O_RSP_VALID = (s.fsm == rpit_pkg::ST_REPLY);
  assign O_RSP_RPID = s.rsp_rpid;
  assign O_RSP_HIT = s.rsp_hit;
  assign O_RSP_ITF = s.rsp_itf;
  assign O_RSP_RP = s.rsp_rp;
  assign O_RSP_PORT = s.rsp_port;
  assign O_CFG_PERMIT = !s.resp_only;
  assign O_AXI_AWREADY = !s.aw_ok && !s.bvalid;
  assign O_AXI_WREADY = !s.w_ok && !s.bvalid;
  assign O_AXI_BVALID = s.bvalid;
  assign O_AXI_BRESP = s.bresp;
  assign O_AXI_ARREADY = !s.rvalid;
  assign O_AXI_RVALID = s.rvalid;
  assign O_AXI_RDATA = s.rdata;
  assign O_AXI_RRESP = s.rresp;

  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RSTN);

  sequence qn_taken;
    cmd_take && I_CMD_OP == rpit_pkg::OP_QUERY_NODE && !I_CMD_DR;
  endsequence
  sequence reply_up;
    O_RSP_VALID && !O_CMD_READY;
  endsequence

  reply_follows_a: assert property (cmd_take |=> reply_up) else $error("no reply after command");
  reply_holds_a: assert property (O_RSP_VALID && !I_RSP_READY |=> O_RSP_VALID && $stable(O_RSP_RPID)
    && $stable(O_RSP_ITF)) else $error("reply dropped early");
  hit_id_a: assert property (qn_taken and full_hit |=> O_RSP_HIT && !O_RSP_ITF && O_RSP_RPID == $past(hit_idx))
    else $error("wrong id on match");
  alloc_entry_a: assert property (qn_taken and !full_hit && can_alloc |=>
    s.stat[O_RSP_RPID] == rpit_pkg::STAT_VALID && s.uid[O_RSP_RPID] == $past(I_CMD_UID)
    && O_RSP_RPID == $past(alloc_idx)) else $error("entry not allocated");
  full_keep_a: assert property (qn_taken and !full_hit && !can_alloc |=> O_RSP_ITF && $stable(s.stat)
    && $stable(s.uid)) else $error("full table changed");
  rcte_free_a: assert property (cmd_take && I_CMD_OP == rpit_pkg::OP_QUIESCE && I_CMD_RCTE |=> !last_live)
    else $error("quiesce left entries");
  quiesce_hold_a: assert property (cmd_take && I_CMD_OP == rpit_pkg::OP_QUIESCE && !I_CMD_RCTE && q_hit
    |=> s.stat[$past(q_idx)] == rpit_pkg::STAT_HELD) else $error("first entry not held");
  reset_free_a: assert property (cmd_take && I_CMD_OP == rpit_pkg::OP_RESET_FRAME |=> s.stat == '0)
    else $error("reset frame left entries");
  reg_report_a: assert property (cmd_take && I_CMD_OP == rpit_pkg::OP_QUERY_REG |=> !any_valid)
    else $error("valid entry after registration");
  lookup_map_a: assert property (cmd_take && I_CMD_OP == rpit_pkg::OP_LOOKUP && s.stat[I_CMD_RPID][1]
    |=> O_RSP_HIT && O_RSP_RP == $past(s.rp[I_CMD_RPID])) else $error("lookup mismatch");
  permit_a: assert property (s.aw_ok && s.w_ok && !s.bvalid && s.awaddr == rpit_pkg::REG_CTRL
    && s.wstrb[0] |=> O_CFG_PERMIT == !$past(s.wdata[rpit_pkg::CTRL_RESP_ONLY_BIT]))
    else $error("responder may configure");
endmodule // rpit_mgr
`default_nettype wire

// *** shared/rpit_pkg.sv ***
// constants, encodings and register map of the return path id table manager
package rpit_pkg;
  localparam int ENTRIES_DEF = 64;
  localparam int UID_W_DEF = 64;
  localparam int RP_W_DEF = 32;
  localparam int PORT_W_DEF = 2;

  localparam logic [2:0] OP_QUERY_NODE = 3'h0;
  localparam logic [2:0] OP_QUIESCE = 3'h1;
  localparam logic [2:0] OP_QUERY_REG = 3'h2;
  localparam logic [2:0] OP_RESET_FRAME = 3'h3;
  localparam logic [2:0] OP_LOOKUP = 3'h4;

  localparam logic [1:0] STAT_FREE = 2'h0;
  localparam logic [1:0] STAT_HELD = 2'h1;
  localparam logic [1:0] STAT_REPORTED = 2'h2;
  localparam logic [1:0] STAT_VALID = 2'h3;

  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_INDEX = 8'h08;
  localparam logic [7:0] REG_ENT_STAT = 8'h0c;
  localparam logic [7:0] REG_ENT_RP = 8'h10;
  localparam logic [7:0] REG_ENT_UID_LO = 8'h14;
  localparam logic [7:0] REG_ENT_UID_HI = 8'h18;
  localparam logic [31:0] CTRL_RST = 32'h00000000;
  localparam int CTRL_RESP_ONLY_BIT = 0;
  localparam int ENT_PORT_LSB = 8;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [0:0] {ST_IDLE = 1'h0, ST_REPLY = 1'h1} rpit_fsm_t;
endpackage

// *** bench/rpit_node_model.sv ***
// remote configuring node model that issues service messages on the command port
`timescale 1ns/1ns
`default_nettype none
module rpit_node_model (
  input wire logic i_clk,
  input wire logic i_cmd_ready,
  input wire logic i_rsp_valid,
  input wire logic [37:0] i_rsp,
  output logic o_cmd_valid,
  output logic [104:0] o_cmd,
  output logic o_rsp_ready
);
  logic [37:0] got;
  logic tmo = 1'b0;
  initial begin
    o_cmd_valid = 1'b0;
    o_cmd = '0;
    o_rsp_ready = 1'b0;
  end
  // gap makes the node slow to accept the reply
  task automatic send(input logic [104:0] c, input int gap);
    int n = 0;
    o_cmd_valid <= 1'b1;
    o_cmd <= c;
    do begin
      @(posedge i_clk);
      n++;
    end while (i_cmd_ready !== 1'b1 && n < 64);
    tmo = tmo || n >= 64;
    o_cmd_valid <= 1'b0;
    // a released payload does not keep its last value
    o_cmd <= ~c;
    repeat (gap) @(posedge i_clk);
    o_rsp_ready <= 1'b1;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (i_rsp_valid !== 1'b1 && n < 64);
    tmo = tmo || n >= 64;
    got = i_rsp;
    o_rsp_ready <= 1'b0;
  endtask
endmodule // rpit_node_model
`default_nettype wire

// *** bench/tb_return_path_id_table_manager.sv ***
// self-checking bench for the return path id table manager
`timescale 1ns/1ns
`default_nettype none
module tb_return_path_id_table_manager;
  localparam int N = 4;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic cmd_valid, cmd_ready, dr, rcte, rsp_valid, rsp_ready, hit, itf, permit, awready, wready, bvalid;
  logic arready, rvalid;
  logic [2:0] op;
  logic [63:0] uid;
  logic [31:0] rp, rsp_rp, rdata;
  logic [1:0] port, rpid, rsp_rpid, rsp_port, bresp, rresp;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, lf = 32'h7a4d;
  logic [1:0] st [N];
  logic [63:0] mu [N];
  logic [31:0] mr [N];
  logic [1:0] mp [N];
  logic [37:0] e;
  logic [2:0] ops [16] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h1, 3'h1, 3'h2, 3'h2, 3'h4, 3'h4,
    3'h3, 3'h7};
  int n_errors = 0;
  int samples_checked = 0;
  always #2 clk = ~clk;
  rpit_mgr #(.ENTRIES(N)) DUT (
    .I_CLK(clk), .I_RSTN(rstn), .I_CMD_VALID(cmd_valid), .O_CMD_READY(cmd_ready), .I_CMD_OP(op),
    .I_CMD_DR(dr), .I_CMD_RCTE(rcte), .I_CMD_UID(uid), .I_CMD_RP(rp), .I_CMD_PORT(port), .I_CMD_RPID(rpid),
    .O_RSP_VALID(rsp_valid), .I_RSP_READY(rsp_ready), .O_RSP_RPID(rsp_rpid), .O_RSP_HIT(hit), .O_RSP_ITF(itf),
    .O_RSP_RP(rsp_rp), .O_RSP_PORT(rsp_port), .O_CFG_PERMIT(permit), .I_AXI_AWVALID(awvalid),
    .O_AXI_AWREADY(awready), .I_AXI_AWADDR(awaddr), .I_AXI_WVALID(wvalid), .O_AXI_WREADY(wready),
    .I_AXI_WDATA(wdata), .I_AXI_WSTRB(4'hf), .O_AXI_BVALID(bvalid), .I_AXI_BREADY(bready), .O_AXI_BRESP(bresp),
    .I_AXI_ARVALID(arvalid), .O_AXI_ARREADY(arready), .I_AXI_ARADDR(araddr), .O_AXI_RVALID(rvalid),
    .I_AXI_RREADY(rready), .O_AXI_RDATA(rdata), .O_AXI_RRESP(rresp));
  rpit_node_model node (
    .i_clk(clk), .i_cmd_ready(cmd_ready), .i_rsp_valid(rsp_valid), .i_rsp({rsp_rpid, hit, itf, rsp_rp, rsp_port}),
    .o_cmd_valid(cmd_valid), .o_cmd({op, dr, rcte, uid, rp, port, rpid}), .o_rsp_ready(rsp_ready));
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic lim(input int n);
    if (n >= 64) begin
      n_errors++;
      $display("CHECK FAILED at %0t: handshake timeout", $time);
      report_and_stop();
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n = 0;
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 64);
    bready <= 1'b0;
    lim(n);
    chk(bresp, er, "bresp");
    @(posedge clk);
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
    int n = 0;
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 64);
    d = rdata;
    rready <= 1'b0;
    lim(n);
    chk(rresp, er, "rresp");
    @(posedge clk);
  endtask
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // reference table: updates st/mu/mr/mp and the expected reply e
  function automatic void model(input logic [104:0] c);
    logic [2:0] o = c[104:102];
    logic [63:0] u = c[99:36];
    logic [1:0] id = c[1:0];
    int f = -1;
    bit first = 1'b1;
    e = '0;
    if (o == 3'h0 && !c[101]) begin
      for (int i = N - 1; i >= 0; i--) if (st[i][1] && mu[i] == u && mr[i] == c[35:4] && mp[i] == c[3:2]) f = i;
      if (f < 0) for (int i = N - 1; i >= 0; i--) if (st[i] == rpit_pkg::STAT_HELD && mu[i] == u) f = i;
      if (f < 0) for (int i = N - 1; i >= 0; i--) if (st[i] == rpit_pkg::STAT_FREE) f = i;
      if (f >= 0 && !st[f][1]) begin
        st[f] = rpit_pkg::STAT_VALID;
        {mu[f], mr[f], mp[f]} = c[99:2];
      end
      e[37:34] = {f[1:0], f >= 0, f < 0};
    end else if (o == 3'h1) begin
      for (int i = 0; i < N; i++) if (st[i] != rpit_pkg::STAT_FREE && mu[i] == u) begin
        st[i] = (first && !c[100]) ? rpit_pkg::STAT_HELD : rpit_pkg::STAT_FREE;
        first = 1'b0;
      end
    end else if (o == 3'h2) begin
      foreach (st[i]) if (st[i] == rpit_pkg::STAT_VALID) st[i] = rpit_pkg::STAT_REPORTED;
    end else if (o == 3'h3) begin
      foreach (st[i]) st[i] = rpit_pkg::STAT_FREE;
    end else if (o == 3'h4 && st[id][1]) begin
      e = {id, 1'b1, 1'b0, mr[id], mp[id]};
    end
  endfunction
  task automatic cmd(input logic [104:0] c, input int gap);
    logic [31:0] v;
    model(c);
    node.send(c, gap);
    lim(node.tmo ? 64 : 0);
    chk(node.got[35:0], e[35:0], "reply");
    if (e[35]) chk(node.got[37:36], e[37:36], "id");
    for (int i = 0; i < N; i++) begin
      axi_wr(rpit_pkg::REG_INDEX, 32'(i), rpit_pkg::RESP_OKAY);
      axi_rd(rpit_pkg::REG_ENT_STAT, v, rpit_pkg::RESP_OKAY);
      chk(v[1:0], st[i], "status");
      if (st[i][1]) begin
        chk(v[9:8], mp[i], "port");
        axi_rd(rpit_pkg::REG_ENT_RP, v, rpit_pkg::RESP_OKAY);
        chk(v, mr[i], "return path");
      end
      if (st[i] != rpit_pkg::STAT_FREE) begin
        axi_rd(rpit_pkg::REG_ENT_UID_LO, v, rpit_pkg::RESP_OKAY);
        chk(v, mu[i][31:0], "uid");
      end
    end
  endtask
  initial begin
    logic [31:0] v;
    foreach (st[i]) st[i] = rpit_pkg::STAT_FREE;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    chk(permit, 1'b1, "permit");
    axi_rd(8'h40, v, rpit_pkg::RESP_DECERR);
    axi_wr(8'h7c, 32'h1, rpit_pkg::RESP_DECERR);
    axi_wr(rpit_pkg::REG_CTRL, 32'h1, rpit_pkg::RESP_OKAY);
    chk(permit, 1'b0, "permit");
    axi_wr(rpit_pkg::REG_CTRL, 32'h0, rpit_pkg::RESP_OKAY);
    for (int i = 0; i < 5; i++) cmd({3'h0, 2'h0, 64'ha0 + 64'(i / 2), 32'(i), i[1:0], 2'h0}, i);
    axi_rd(rpit_pkg::REG_STATUS, v, rpit_pkg::RESP_OKAY);
    chk(v, 32'h6, "table full status");
    cmd({3'h0, 2'h2, 64'ha0, 32'h0, 4'h0}, 0);
    cmd({3'h0, 2'h0, 64'ha0, 32'h0, 4'h0}, 2);
    cmd({3'h2, 2'h0, 64'h0, 32'h0, 4'h0}, 0);
    cmd({3'h1, 2'h0, 64'ha0, 32'h0, 4'h0}, 1);
    cmd({3'h0, 2'h0, 64'ha0, 32'h5, 4'h4}, 0);
    cmd({3'h1, 2'h1, 64'ha1, 32'h0, 4'h0}, 0);
    cmd({3'h4, 2'h0, 64'h0, 32'h0, 4'h0}, 1);
    cmd({3'h3, 2'h0, 64'h0, 32'h0, 4'h0}, 0);
    for (int k = 0; k < 60; k++) begin
      lf = lfsr(lf);
      cmd({ops[lf[3:0]], lf[4] & lf[5], lf[6], 64'ha0 + 64'(lf[8:7]), 31'h0, lf[9], 1'b0, lf[10], lf[12:11]},
        lf[13] ? 3 : 0);
    end
    report_and_stop();
  end
endmodule // tb_return_path_id_table_manager
`default_nettype wire
